// *** rtl/fsq_sequencer.sv ***
// Flash row erase and program sequencer with latches and unlock key.
// Assumes the CPU halts while stall is high and the array obeys strobes.
`timescale 1ns/1ns
module fsq_sequencer #(
    parameter int ERASE_CYCLES = fsq_pkg::ERASE_CYCLES,
    parameter int PROG_CYCLES = fsq_pkg::PROG_CYCLES,
    parameter int ROW_WORDS = fsq_pkg::ROW_WORDS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // CPU stall
    output logic cpu_stall,
    // Flash array
    output logic flash_erase,
    output logic flash_prog_wr,
    output logic [23:0] flash_addr,
    output logic [23:0] flash_data
);

    localparam int IW = $clog2(ROW_WORDS);

    typedef struct packed {
        fsq_pkg::fsq_st_t st;
        logic go;
        logic flash_write_enable;
        logic err;
        logic erase;
        logic [3:0] op;
        logic [7:0] page;
        logic [15:0] ofs;
        logic [fsq_pkg::CNT_W-1:0] cnt;
        logic [IW:0] wcnt;
        logic [23:0] base;
        logic [15:0] rdata;
        logic stall;
        logic f_erase;
        logic f_wr;
        logic [23:0] f_addr;
        logic [23:0] f_data;
    } fsq_state_t;

    fsq_state_t s;
    fsq_state_t next_s;
    logic [15:0] lat_lo [ROW_WORDS];
    logic [7:0] lat_hi [ROW_WORDS];
    logic armed;
    logic key_wr;
    logic other_wr;
    logic go_wr;
    logic do_erase;
    logic do_prog;

    function automatic logic hit(input logic [2:0] a);
        hit = (reg_addr == a);
    endfunction : hit

    assign key_wr = reg_wr && hit(fsq_pkg::REG_KEY);
    assign other_wr = reg_wr && !hit(fsq_pkg::REG_KEY);
    assign go_wr = reg_wr && hit(fsq_pkg::REG_CTRL) &&
                   reg_wdata[fsq_pkg::CTRL_GO] && s.st == fsq_pkg::FSQ_IDLE;
    assign do_erase = go_wr && armed && reg_wdata[fsq_pkg::CTRL_FLASH_WRITE_ENABLE] &&
        reg_wdata[fsq_pkg::CTRL_ERASE] &&
        reg_wdata[fsq_pkg::OP_MSB:0] == fsq_pkg::OP_PAGE_ERASE;
    assign do_prog = go_wr && armed && reg_wdata[fsq_pkg::CTRL_FLASH_WRITE_ENABLE] &&
        !reg_wdata[fsq_pkg::CTRL_ERASE] &&
        reg_wdata[fsq_pkg::OP_MSB:0] == fsq_pkg::OP_ROW_PROG;

    fsq_unlock u_unlock (
        .clk(clk),
        .reset(reset),
        .key_wr(key_wr),
        .key_data(reg_wdata[7:0]),
        .other_wr(other_wr),
        .armed(armed)
    );

    // ****************************************************************
    // Program latches
    // ****************************************************************
    // Latches hold no reset; software loads them before every row.
    // latch loading
    always_ff @(posedge clk) begin
        if (reg_wr && hit(fsq_pkg::REG_LAT_LO) &&
            s.st == fsq_pkg::FSQ_IDLE) begin
            lat_lo[s.ofs[IW:1]] <= reg_wdata;
        end
        if (reg_wr && hit(fsq_pkg::REG_LAT_HI) &&
            s.st == fsq_pkg::FSQ_IDLE) begin
            lat_hi[s.ofs[IW:1]] <= reg_wdata[7:0];
        end
    end

    // ****************************************************************
    // Registers and sequencer
    // ****************************************************************
    always_comb begin
        next_s = s;
        next_s.f_erase = 1'b0;
        next_s.f_wr = 1'b0;
        next_s.rdata = fsq_pkg::RESET_WORD;
        if (reg_rd) begin
            case (reg_addr)
                fsq_pkg::REG_CTRL: begin
                    next_s.rdata[fsq_pkg::CTRL_GO] = s.go;
                    next_s.rdata[fsq_pkg::CTRL_FLASH_WRITE_ENABLE] = s.flash_write_enable;
                    next_s.rdata[fsq_pkg::CTRL_ERR] = s.err;
                    next_s.rdata[fsq_pkg::CTRL_ERASE] = s.erase;
                    next_s.rdata[fsq_pkg::OP_MSB:0] = s.op;
                end
                fsq_pkg::REG_PAGE: next_s.rdata[7:0] = s.page;
                fsq_pkg::REG_OFS: next_s.rdata = s.ofs;
                default: next_s.rdata = fsq_pkg::RESET_WORD;
            endcase
        end
        // Writes are ignored while busy; the CPU is stalled then anyway.
        if (reg_wr && s.st == fsq_pkg::FSQ_IDLE) begin
            case (reg_addr)
                fsq_pkg::REG_CTRL: begin
                    next_s.flash_write_enable = reg_wdata[fsq_pkg::CTRL_FLASH_WRITE_ENABLE];
                    next_s.err = reg_wdata[fsq_pkg::CTRL_ERR];
                    next_s.erase = reg_wdata[fsq_pkg::CTRL_ERASE];
                    next_s.op = reg_wdata[fsq_pkg::OP_MSB:0];
                    if (reg_wdata[fsq_pkg::CTRL_GO] && !do_erase &&
                        !do_prog) begin
                        next_s.err = 1'b1;
                    end
                end
                fsq_pkg::REG_PAGE: next_s.page = reg_wdata[7:0];
                fsq_pkg::REG_OFS: next_s.ofs = reg_wdata;
                fsq_pkg::REG_LAT_HI: next_s.ofs = s.ofs + fsq_pkg::OFS_STEP;
                default: next_s.err = next_s.err;
            endcase
        end
        case (s.st)
            fsq_pkg::FSQ_IDLE: begin
                if (do_erase) begin
                    next_s.st = fsq_pkg::FSQ_ERASE;
                    next_s.go = 1'b1;
                    next_s.stall = 1'b1;
                    next_s.cnt = fsq_pkg::CNT_W'(ERASE_CYCLES - 1);
                    next_s.f_erase = 1'b1;
                    next_s.f_addr = {s.page, s.ofs} &
                        ~24'((1 << fsq_pkg::PAGE_ADDR_LSB) - 1);
                end else if (do_prog) begin
                    next_s.st = fsq_pkg::FSQ_PROG;
                    next_s.go = 1'b1;
                    next_s.stall = 1'b1;
                    next_s.cnt = fsq_pkg::CNT_W'(PROG_CYCLES - 1);
                    next_s.wcnt = '0;
                    next_s.base = {s.page, s.ofs} &
                        ~24'((1 << fsq_pkg::ROW_ADDR_LSB) - 1);
                end
            end
            fsq_pkg::FSQ_ERASE: begin
                next_s.cnt = s.cnt - 1'b1;
                if (s.cnt == '0) begin
                    next_s.st = fsq_pkg::FSQ_IDLE;
                    next_s.go = 1'b0;
                    next_s.stall = 1'b0;
                end
            end
            fsq_pkg::FSQ_PROG: begin
                next_s.cnt = s.cnt - 1'b1;
                if (s.wcnt < (IW + 1)'(ROW_WORDS)) begin
                    next_s.f_wr = 1'b1;
                    next_s.f_addr = s.base +
                        24'({s.wcnt[IW-1:0], 1'b0});
                    next_s.f_data = {lat_hi[s.wcnt[IW-1:0]],
                                     lat_lo[s.wcnt[IW-1:0]]};
                    next_s.wcnt = s.wcnt + 1'b1;
                end
                if (s.cnt == '0) begin
                    next_s.st = fsq_pkg::FSQ_IDLE;
                    next_s.go = 1'b0;
                    next_s.stall = 1'b0;
                end
            end
            default: next_s.st = fsq_pkg::FSQ_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s <= '0;
            s.st <= fsq_pkg::FSQ_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata = s.rdata;
    assign cpu_stall = s.stall;
    assign flash_erase = s.f_erase;
    assign flash_prog_wr = s.f_wr;
    assign flash_addr = s.f_addr;
    assign flash_data = s.f_data;

    // ****************************************************************
    // Checks
    // ****************************************************************
    AST_KEY_READS_ZERO:
    assert property (@(posedge clk) disable iff (reset)
        (reg_rd && reg_addr == fsq_pkg::REG_KEY) |=> reg_rdata == 16'h0000)
    else $error("Key register read not zero.");

    AST_START_NEEDS_UNLOCK:
    assert property (@(posedge clk) disable iff (reset)
        (s.st == fsq_pkg::FSQ_IDLE ##1 s.st != fsq_pkg::FSQ_IDLE) |->
        $past(armed))
    else $error("Operation began without unlock.");

    AST_ERASE_STALLS:
    assert property (@(posedge clk) disable iff (reset)
        do_erase |=> (cpu_stall && flash_erase && s.go) ##1
        (cpu_stall && !flash_erase))
    else $error("Erase start did not stall with one pulse.");

    AST_PROG_STALLS:
    assert property (@(posedge clk) disable iff (reset)
        do_prog |=> cpu_stall ##1 (cpu_stall && flash_prog_wr))
    else $error("Program start did not stall and write.");

    AST_ERASE_CLEARS_GO:
    assert property (@(posedge clk) disable iff (reset)
        (s.st == fsq_pkg::FSQ_ERASE && s.cnt == '0) |=>
        (!s.go && !cpu_stall && s.st == fsq_pkg::FSQ_IDLE))
    else $error("Go not cleared after erase.");

    AST_PROG_CLEARS_GO:
    assert property (@(posedge clk) disable iff (reset)
        (s.st == fsq_pkg::FSQ_PROG && s.cnt == '0) |=>
        (!s.go && !cpu_stall && s.wcnt == (IW + 1)'(ROW_WORDS)))
    else $error("Go not cleared or row short after program.");

    AST_ERASE_PAGE_ALIGNED:
    assert property (@(posedge clk) disable iff (reset)
        flash_erase |-> flash_addr[fsq_pkg::PAGE_ADDR_LSB-1:0] == '0)
    else $error("Erase address not page aligned.");

    AST_ROW_WORD_LIMIT:
    assert property (@(posedge clk) disable iff (reset)
        flash_prog_wr |-> (s.wcnt >= 1 && s.wcnt <= (IW + 1)'(ROW_WORDS) &&
        flash_addr[fsq_pkg::ROW_ADDR_LSB-1:0] ==
        {$past(s.wcnt[IW-1:0]), 1'b0}))
    else $error("Row write outside latch range.");

endmodule : fsq_sequencer

// *** rtl/fsq_pkg.sv ***
// Shared constants and types for the flash row erase and program sequencer.
// Assumes a 16-bit register port and one 10 MHz system clock.
// Contract
// - Eight-bit write-only unlock key field.
// - Key register upper byte reads zero.
// - Program one row, erase eight-row pages.
// - Row program writes 64 latched instructions.
// - No operation without unlock just before.
// - Go starts erase and stalls CPU.
// - Go starts row program and stalls CPU.
// - Go clears when erase completes.
// - Go clears when row program completes.
package fsq_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_KEY = 3'h1;
    localparam logic [2:0] REG_PAGE = 3'h2;
    localparam logic [2:0] REG_OFS = 3'h3;
    localparam logic [2:0] REG_LAT_LO = 3'h4;
    localparam logic [2:0] REG_LAT_HI = 3'h5;

    // ****************************************************************
    // Control fields
    // ****************************************************************
    localparam int CTRL_GO = 15;
    localparam int CTRL_FLASH_WRITE_ENABLE = 14;
    localparam int CTRL_ERR = 13;
    localparam int CTRL_ERASE = 6;
    localparam int OP_MSB = 3;
    localparam logic [3:0] OP_PAGE_ERASE = 4'h2;
    localparam logic [3:0] OP_ROW_PROG = 4'h1;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    // ****************************************************************
    // Geometry and timing
    // ****************************************************************
    localparam int ROW_WORDS = 64;
    localparam int ROW_ADDR_LSB = 7;
    localparam int PAGE_ADDR_LSB = 10;
    localparam logic [15:0] OFS_STEP = 16'h0002;
    localparam int CLK_FREQ_MHZ = 10;
    localparam int ERASE_TIME_US = 20000;
    localparam int PROG_TIME_US = 1500;
    localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_FREQ_MHZ;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_FREQ_MHZ;
    localparam int CNT_W = 24;

    typedef enum logic [1:0] {
        FSQ_KEY_IDLE,
        FSQ_KEY_GOT_FIRST,
        FSQ_KEY_ARMED
    } fsq_key_st_t;

    typedef enum logic [1:0] {
        FSQ_IDLE,
        FSQ_ERASE,
        FSQ_PROG
    } fsq_st_t;

endpackage : fsq_pkg

// *** rtl/fsq_unlock.sv ***
// Unlock key tracker for the flash sequencer.
// Assumes key writes and other writes arrive as one-cycle strobes.
`timescale 1ns/1ns
module fsq_unlock (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Write events
    input wire logic key_wr,
    input wire logic [7:0] key_data,
    input wire logic other_wr,
    // Unlock state
    output logic armed
);

    typedef struct packed {
        fsq_pkg::fsq_key_st_t st;
    } fsq_unlock_state_t;

    fsq_unlock_state_t s;
    fsq_unlock_state_t next_s;

    // ****************************************************************
    // Key sequence
    // ****************************************************************
    always_comb begin
        next_s = s;
        if (key_wr) begin
            if (key_data == fsq_pkg::KEY_FIRST) begin
                next_s.st = fsq_pkg::FSQ_KEY_GOT_FIRST;
            end else if (key_data == fsq_pkg::KEY_SECOND &&
                         s.st == fsq_pkg::FSQ_KEY_GOT_FIRST) begin
                next_s.st = fsq_pkg::FSQ_KEY_ARMED;
            end else begin
                next_s.st = fsq_pkg::FSQ_KEY_IDLE;
            end
        end else if (other_wr) begin
            next_s.st = fsq_pkg::FSQ_KEY_IDLE;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s <= '{st: fsq_pkg::FSQ_KEY_IDLE};
        end else begin
            s <= next_s;
        end
    end

    assign armed = (s.st == fsq_pkg::FSQ_KEY_ARMED);

    AST_KEY_PAIR_ARMS:
    assert property (@(posedge clk) disable iff (reset)
        (key_wr && key_data == fsq_pkg::KEY_FIRST) ##1
        (key_wr && key_data == fsq_pkg::KEY_SECOND) |=> armed)
    else $error("Ordered key pair did not arm.");

    AST_KEY_BREAK_DISARMS:
    assert property (@(posedge clk) disable iff (reset)
        (key_wr && key_data != fsq_pkg::KEY_FIRST &&
         key_data != fsq_pkg::KEY_SECOND) |=> (!armed ##1 !armed))
    else $error("Broken key sequence left partial unlock.");

endmodule : fsq_unlock

// *** test/fsq_sequencer_bench.sv ***
// Self-checking bench for the flash row erase and program sequencer.
// Assumes short erase and program counts; drives the register port only.
`timescale 1ns/1ns
module fsq_sequencer_bench;
    // ****************************************************************
    // Signals
    // ****************************************************************
    localparam int ERASE_N = 8;
    localparam int PROG_N = 80;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [15:0] reg_rdata;
    logic cpu_stall;
    logic flash_erase;
    logic flash_prog_wr;
    logic [23:0] flash_addr;
    logic [23:0] flash_data;
    logic rd_d = 1'h0;
    logic [31:0] lfsr = 32'h764B5A0C;
    logic [48:0] f;
    int miscompares = 0;
    int checked = 0;
    logic [15:0] rq[$];
    logic [48:0] fq[$];

    always #50 clk = ~clk;

    fsq_sequencer #(.ERASE_CYCLES(ERASE_N), .PROG_CYCLES(PROG_N),
        .ROW_WORDS(fsq_pkg::ROW_WORDS)) i_fsq_sequencer (
        .clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cpu_stall(cpu_stall),
        .flash_erase(flash_erase), .flash_prog_wr(flash_prog_wr),
        .flash_addr(flash_addr), .flash_data(flash_data));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand

    task automatic chk(input logic [23:0] got, input logic [23:0] exp,
        input string what);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: %s got %h expected %h", $time, what,
                got, exp);
        end
    endtask : chk

    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    // Strobes stay up between back-to-back calls, so no signal is
    // assigned twice in one time step.
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        reg_rd <= 1'h0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [15:0] exp);
        rq.push_back(exp);
        reg_addr <= a;
        reg_wr <= 1'h0;
        reg_rd <= 1'h1;
        @(posedge clk);
    endtask : rd

    task automatic idle;
        reg_wr <= 1'h0;
        reg_rd <= 1'h0;
        @(posedge clk);
    endtask : idle

    // Unlock kinds: 0 none, 1 proper pair, 2 bad key, 3 other write.
    task automatic go_try(input logic [15:0] v, input int unl,
        input int exp_n);
        int n;
        logic [15:0] fin;
        n = 0;
        fin = (exp_n > 0) ? (v & 16'h7FFF) : ((v & 16'h7FFF) | 16'h2000);
        wr(fsq_pkg::REG_CTRL, v & 16'h7FFF);
        if (unl > 0) wr(fsq_pkg::REG_KEY, {8'h00, fsq_pkg::KEY_FIRST});
        if (unl == 2) wr(fsq_pkg::REG_KEY, 16'h0012);
        if (unl == 3) wr(fsq_pkg::REG_PAGE, 16'h0000);
        if (unl > 0) wr(fsq_pkg::REG_KEY, {8'h00, fsq_pkg::KEY_SECOND});
        wr(fsq_pkg::REG_CTRL, v);
        reg_wr <= 1'h0;
        // wait out busy
        // The stall is read before this edge updates it, so n counts
        // the cycles that stood high since the start edge.
        for (int k = 0; k < 200; k++) begin
            @(posedge clk);
            if (cpu_stall !== 1'h1) break;
            n++;
            reg_rd <= (n == 1);
            reg_addr <= fsq_pkg::REG_CTRL;
            if (n == 1) rq.push_back(v);
        end
        if (n >= 200) begin
            miscompares++;
            print_verdict;
        end
        chk(24'(n), 24'(exp_n), "stall length");
        rd(fsq_pkg::REG_CTRL, fin);
        idle;
        chk(24'(fq.size()), 24'h0, "flash strobes missing");
    endtask : go_try

    // ****************************************************************
    // Result monitor
    // ****************************************************************
    always @(posedge clk) begin
        rd_d <= reg_rd;
    end

    always @(negedge clk) begin
        if (rd_d) begin
            if (rq.size() == 0) begin
                chk(24'h1, 24'h0, "unexpected read");
            end else begin
                chk({8'h00, reg_rdata}, {8'h00, rq.pop_front()}, "read");
            end
        end
        if (flash_erase === 1'h1 || flash_prog_wr === 1'h1) begin
            if (fq.size() == 0) begin
                chk(24'h1, 24'h0, "unexpected flash strobe");
            end else begin
                f = fq.pop_front();
                chk({23'h0, flash_erase}, {23'h0, f[48]}, "kind");
                chk(flash_addr, f[47:24], "flash address");
                if (!f[48]) chk(flash_data, f[23:0], "data");
            end
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [7:0] pg;
        logic [15:0] base;
        logic [23:0] w;
        repeat (20) @(posedge clk);
        reset <= 1'h0;
        @(posedge clk);
        rd(fsq_pkg::REG_CTRL, fsq_pkg::RESET_WORD);
        wr(fsq_pkg::REG_KEY, 16'hFF5A);
        rd(fsq_pkg::REG_KEY, 16'h0000);
        rd(3'h6, 16'h0000);
        idle;
        $display("Test register read back done");
        go_try(16'hC042, 0, 0);
        go_try(16'hC042, 2, 0);
        go_try(16'hC042, 3, 0);
        go_try(16'hC041, 1, 0);
        go_try(16'hC002, 1, 0);
        go_try(16'h8042, 1, 0);
        $display("Test refused starts done");
        lfsr = next_rand(lfsr);
        wr(fsq_pkg::REG_PAGE, {8'h00, lfsr[7:0]});
        wr(fsq_pkg::REG_OFS, lfsr[31:16]);
        fq.push_back({1'h1, lfsr[7:0], lfsr[31:26], 10'h000, 24'h000000});
        go_try(16'hC042, 1, ERASE_N);
        go_try(16'hC042, 0, 0);
        $display("Test page erase done");
        lfsr = next_rand(lfsr);
        pg = lfsr[7:0];
        base = {lfsr[15:7], 7'h00};
        wr(fsq_pkg::REG_PAGE, {8'h00, pg});
        for (int r = 0; r < 2; r++) begin
            wr(fsq_pkg::REG_OFS, base);
            for (int i = 0; i < fsq_pkg::ROW_WORDS; i++) begin
                lfsr = next_rand(lfsr);
                w = lfsr[23:0];
                wr(fsq_pkg::REG_LAT_LO, w[15:0]);
                wr(fsq_pkg::REG_LAT_HI, {8'h00, w[23:16]});
                fq.push_back({1'h0, pg, base + 16'(2 * i), w});
            end
            wr(fsq_pkg::REG_OFS, base);
            go_try(16'hC001, 1, PROG_N);
            base = base + 16'h0080;
        end
        $display("Test row program done");
        idle;
        print_verdict;
    end
endmodule : fsq_sequencer_bench
